// ===== core/bffs_pkg.sv
package bffs_pkg;
  // queue geometry defaults
  localparam int DATA_W = 36;
  localparam int DEPTH = 256;
  localparam int BYTE_W = 9;
  localparam int BYTES = 4;
  // register port
  localparam int ADDR_W = 8;
  localparam int RDATA_W = 32;
  localparam logic [7:0] OFF_AB_EMPTY = 8'h00;
  localparam logic [7:0] OFF_BA_EMPTY = 8'h04;
  localparam logic [7:0] OFF_AB_FULL = 8'h08;
  localparam logic [7:0] OFF_BA_FULL = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_CLEAR = 8'h14;
  localparam logic [7:0] OFF_ENABLE = 8'h18;
  localparam logic [7:0] OFF_CONFIG = 8'h1C;
  // flag bit positions in status, enable, clear and flag vectors
  localparam int FLG_A_AE = 0;
  localparam int FLG_B_AE = 1;
  localparam int FLG_A_AF = 2;
  localparam int FLG_B_AF = 3;
  localparam int NFLG = 4;
  // config register fields
  localparam int CFG_ORDER = 0;
  localparam int CFG_FALL_THROUGH_SELECT = 1;
  // default offset choices on the two select inputs
  localparam logic [1:0] DSEL_8 = 2'h0;
  localparam logic [1:0] DSEL_16 = 2'h1;
  localparam logic [1:0] DSEL_64 = 2'h2;
  localparam int DEF_OFF_8 = 8;
  localparam int DEF_OFF_16 = 16;
  localparam int DEF_OFF_64 = 64;
  // reset values
  localparam logic [3:0] FLAGS_RST = 4'hC;
  localparam logic [3:0] ENABLE_RST = 4'h0;
endpackage

// ===== core/bffs_top.sv
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module bffs_top import bffs_pkg::*; #(
  parameter int DW = DATA_W,
  parameter int QDEPTH = DEPTH
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // configuration pins
  input wire logic MASTER_RESET_N_IN,
  input wire logic ORDER_TIMING_SELECT_IN,
  input wire logic FLAG_DEFAULT_SEL0_IN,
  input wire logic FLAG_DEFAULT_SEL1_IN,
  input wire logic SIDE_B_BYTE_MODE_IN,
  // port A
  input wire logic SIDE_A_SELECT_IN,
  input wire logic SIDE_A_WRITE_EN_IN,
  input wire logic SIDE_A_READ_EN_IN,
  input wire logic [DW-1:0] SIDE_A_DATA_IN,
  output logic [DW-1:0] SIDE_A_DATA_OUT,
  output logic SIDE_A_DATA_OE_OUT,
  output logic SIDE_A_ALMOST_EMPTY_N_OUT,
  output logic SIDE_A_ALMOST_FULL_N_OUT,
  // port B
  input wire logic SIDE_B_SELECT_IN,
  input wire logic SIDE_B_WRITE_EN_IN,
  input wire logic SIDE_B_READ_EN_IN,
  input wire logic [DW-1:0] SIDE_B_DATA_IN,
  output logic [DW-1:0] SIDE_B_DATA_OUT,
  output logic SIDE_B_DATA_OE_OUT,
  output logic SIDE_B_ALMOST_EMPTY_N_OUT,
  output logic SIDE_B_ALMOST_FULL_N_OUT,
  // register port
  input wire logic [ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [RDATA_W-1:0] REG_WDATA_IN,
  input wire logic REG_WRITE_IN,
  input wire logic REG_READ_IN,
  output logic [RDATA_W-1:0] REG_RDATA_OUT,
  output logic IRQ_OUT
);
  localparam int PW = $clog2(QDEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(QDEPTH);

  typedef struct packed {
    logic [CW-1:0] ab_cnt;
    logic [CW-1:0] ba_cnt;
    logic [PW-1:0] ab_wr;
    logic [PW-1:0] ab_rd;
    logic [PW-1:0] ba_wr;
    logic [PW-1:0] ba_rd;
    logic [CW-1:0] ab_empty_off;
    logic [CW-1:0] ba_empty_off;
    logic [CW-1:0] ab_full_off;
    logic [CW-1:0] ba_full_off;
    logic order;
    logic fall_through_select;
    logic [1:0] b_rd_idx;
    logic [1:0] b_wr_idx;
    logic [DW-1:0] b_acc;
    logic [NFLG-1:0] flg_s1;
    logic [NFLG-1:0] flg;
    logic [NFLG-1:0] flg_q;
    logic [NFLG-1:0] status;
    logic [NFLG-1:0] enable;
    logic irq;
    logic [RDATA_W-1:0] rdata;
    logic [DW-1:0] a_dout;
    logic [DW-1:0] b_dout;
    logic a_oe;
    logic b_oe;
  } bffs_state_t;

  bffs_state_t c;
  bffs_state_t n;
  logic [DW-1:0] ab_mem [QDEPTH];
  logic [DW-1:0] ba_mem [QDEPTH];
  logic ab_push;
  logic ab_pop;
  logic ba_push;
  logic ba_pop;
  logic [DW-1:0] ba_wdata;
  logic [NFLG-1:0] flg_raw;

  // position of a narrow byte lane for the given transfer index
  function automatic logic [1:0] lane(input logic [1:0] idx, input logic big);
    lane = big ? 2'(BYTES - 1) - idx : idx;
  endfunction

  // extract one byte lane of a word
  function automatic logic [DW-1:0] pick(input logic [DW-1:0] w, input logic [1:0] ln);
    pick = DW'(w[ln*BYTE_W +: BYTE_W]);
  endfunction

  // default offset for the two select inputs, programmed value kept on 11
  function automatic logic [CW-1:0] dflt(input logic [1:0] s, input logic [CW-1:0] keep);
    if (s == DSEL_8) begin
      dflt = CW'(DEF_OFF_8);
    end else if (s == DSEL_16) begin
      dflt = CW'(DEF_OFF_16);
    end else if (s == DSEL_64) begin
      dflt = CW'(DEF_OFF_64);
    end else begin
      dflt = keep;
    end
  endfunction

  // queue transfer qualifiers
  always_comb begin
    ab_push = MASTER_RESET_N_IN && SIDE_A_SELECT_IN && SIDE_A_WRITE_EN_IN
      && (c.ab_cnt != FULL_CNT);
    ab_pop = MASTER_RESET_N_IN && SIDE_B_SELECT_IN && SIDE_B_READ_EN_IN
      && !SIDE_B_WRITE_EN_IN && (c.ab_cnt != '0)
      && (!SIDE_B_BYTE_MODE_IN || c.b_rd_idx == 2'(BYTES - 1));
    ba_push = MASTER_RESET_N_IN && SIDE_B_SELECT_IN && SIDE_B_WRITE_EN_IN
      && (c.ba_cnt != FULL_CNT)
      && (!SIDE_B_BYTE_MODE_IN || c.b_wr_idx == 2'(BYTES - 1));
    ba_pop = MASTER_RESET_N_IN && SIDE_A_SELECT_IN && SIDE_A_READ_EN_IN
      && !SIDE_A_WRITE_EN_IN && (c.ba_cnt != '0);
    ba_wdata = SIDE_B_DATA_IN;
    if (SIDE_B_BYTE_MODE_IN) begin
      ba_wdata = c.b_acc;
      ba_wdata[lane(c.b_wr_idx, c.order)*BYTE_W +: BYTE_W] = SIDE_B_DATA_IN[BYTE_W-1:0];
    end
  end

  // unsynchronized flag levels, active low
  always_comb begin
    flg_raw[FLG_A_AE] = !(c.ba_cnt <= c.ba_empty_off);
    flg_raw[FLG_B_AE] = !(c.ab_cnt <= c.ab_empty_off);
    flg_raw[FLG_A_AF] = !(FULL_CNT - c.ab_cnt <= c.ab_full_off);
    flg_raw[FLG_B_AF] = !(FULL_CNT - c.ba_cnt <= c.ba_full_off);
  end

  // queue storage
  always_ff @(posedge CLK_IN) begin
    if (ab_push) begin
      ab_mem[c.ab_wr] <= SIDE_A_DATA_IN;
    end
    if (ba_push) begin
      ba_mem[c.ba_wr] <= ba_wdata;
    end
  end

  // next state
  always_comb begin
    logic [PW-1:0] ab_rd_n;
    logic [PW-1:0] ba_rd_n;
    logic [1:0] rd_idx_n;
    ab_rd_n = '0;
    ba_rd_n = '0;
    rd_idx_n = '0;
    n = c;
    // data bus direction follows select and write enable
    n.a_oe = SIDE_A_SELECT_IN && !SIDE_A_WRITE_EN_IN;
    n.b_oe = SIDE_B_SELECT_IN && !SIDE_B_WRITE_EN_IN;
    // queue pointers and counts
    n.ab_wr = c.ab_wr + PW'(ab_push);
    n.ba_wr = c.ba_wr + PW'(ba_push);
    ab_rd_n = c.ab_rd + PW'(ab_pop);
    ba_rd_n = c.ba_rd + PW'(ba_pop);
    n.ab_rd = ab_rd_n;
    n.ba_rd = ba_rd_n;
    n.ab_cnt = c.ab_cnt + CW'(ab_push) - CW'(ab_pop);
    n.ba_cnt = c.ba_cnt + CW'(ba_push) - CW'(ba_pop);
    // narrow-mode lane counters on port B
    rd_idx_n = c.b_rd_idx;
    if (SIDE_B_BYTE_MODE_IN && SIDE_B_SELECT_IN && SIDE_B_READ_EN_IN
        && !SIDE_B_WRITE_EN_IN && c.ab_cnt != '0) begin
      rd_idx_n = c.b_rd_idx + 2'h1;
    end
    n.b_rd_idx = rd_idx_n;
    if (SIDE_B_BYTE_MODE_IN && SIDE_B_SELECT_IN && SIDE_B_WRITE_EN_IN
        && c.ba_cnt != FULL_CNT) begin
      n.b_wr_idx = c.b_wr_idx + 2'h1;
      n.b_acc = ba_push ? '0 : ba_wdata;
    end
    // output data: fall-through shows the head, standard loads on a read
    if (c.fall_through_select) begin
      n.a_dout = ba_mem[ba_rd_n];
      n.b_dout = SIDE_B_BYTE_MODE_IN
        ? pick(ab_mem[ab_rd_n], lane(rd_idx_n, c.order)) : ab_mem[ab_rd_n];
    end else begin
      if (ba_pop) begin
        n.a_dout = ba_mem[c.ba_rd];
      end
      if (rd_idx_n != c.b_rd_idx || ab_pop) begin
        n.b_dout = SIDE_B_BYTE_MODE_IN
          ? pick(ab_mem[c.ab_rd], lane(c.b_rd_idx, c.order)) : ab_mem[c.ab_rd];
      end
    end
    // two synchronizing stages for the partial flags
    n.flg_s1 = flg_raw;
    n.flg = c.flg_s1;
    n.flg_q = c.flg;
    // timing mode follows the select pin once out of master reset
    n.fall_through_select = !ORDER_TIMING_SELECT_IN;
    if (!MASTER_RESET_N_IN) begin
      n.fall_through_select = c.fall_through_select;
      n.order = ORDER_TIMING_SELECT_IN;
      n.ab_cnt = '0;
      n.ba_cnt = '0;
      n.ab_wr = '0;
      n.ab_rd = '0;
      n.ba_wr = '0;
      n.ba_rd = '0;
      n.b_rd_idx = '0;
      n.b_wr_idx = '0;
      n.b_acc = '0;
      n.ab_empty_off = dflt({FLAG_DEFAULT_SEL1_IN, FLAG_DEFAULT_SEL0_IN}, c.ab_empty_off);
      n.ba_empty_off = dflt({FLAG_DEFAULT_SEL1_IN, FLAG_DEFAULT_SEL0_IN}, c.ba_empty_off);
      n.ab_full_off = dflt({FLAG_DEFAULT_SEL1_IN, FLAG_DEFAULT_SEL0_IN}, c.ab_full_off);
      n.ba_full_off = dflt({FLAG_DEFAULT_SEL1_IN, FLAG_DEFAULT_SEL0_IN}, c.ba_full_off);
    end
    // register writes
    if (REG_WRITE_IN) begin
      if (REG_ADDR_IN == OFF_AB_EMPTY) begin
        n.ab_empty_off = REG_WDATA_IN[CW-1:0];
      end else if (REG_ADDR_IN == OFF_BA_EMPTY) begin
        n.ba_empty_off = REG_WDATA_IN[CW-1:0];
      end else if (REG_ADDR_IN == OFF_AB_FULL) begin
        n.ab_full_off = REG_WDATA_IN[CW-1:0];
      end else if (REG_ADDR_IN == OFF_BA_FULL) begin
        n.ba_full_off = REG_WDATA_IN[CW-1:0];
      end else if (REG_ADDR_IN == OFF_CLEAR) begin
        n.status = c.status & ~REG_WDATA_IN[NFLG-1:0];
      end else if (REG_ADDR_IN == OFF_ENABLE) begin
        n.enable = REG_WDATA_IN[NFLG-1:0];
      end
    end
    // a pin that fell at the last edge sets sticky status, set wins over clear
    n.status = n.status | (c.flg_q & ~c.flg);
    n.irq = |(n.status & n.enable);
    // register reads, data valid the cycle after the strobe only
    n.rdata = '0;
    if (REG_READ_IN) begin
      if (REG_ADDR_IN == OFF_AB_EMPTY) begin
        n.rdata = RDATA_W'(c.ab_empty_off);
      end else if (REG_ADDR_IN == OFF_BA_EMPTY) begin
        n.rdata = RDATA_W'(c.ba_empty_off);
      end else if (REG_ADDR_IN == OFF_AB_FULL) begin
        n.rdata = RDATA_W'(c.ab_full_off);
      end else if (REG_ADDR_IN == OFF_BA_FULL) begin
        n.rdata = RDATA_W'(c.ba_full_off);
      end else if (REG_ADDR_IN == OFF_STATUS) begin
        n.rdata = RDATA_W'(c.status);
      end else if (REG_ADDR_IN == OFF_ENABLE) begin
        n.rdata = RDATA_W'(c.enable);
      end else if (REG_ADDR_IN == OFF_CONFIG) begin
        n.rdata[CFG_ORDER] = c.order;
        n.rdata[CFG_FALL_THROUGH_SELECT] = c.fall_through_select;
      end
    end
  end

  // state register
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      c <= '0;
      c.ab_empty_off <= CW'(DEF_OFF_8);
      c.ba_empty_off <= CW'(DEF_OFF_8);
      c.ab_full_off <= CW'(DEF_OFF_8);
      c.ba_full_off <= CW'(DEF_OFF_8);
      c.flg_s1 <= FLAGS_RST;
      c.flg <= FLAGS_RST;
      c.flg_q <= FLAGS_RST;
      c.enable <= ENABLE_RST;
    end else begin
      c <= n;
    end
  end

  // outputs straight from the state register
  assign SIDE_A_DATA_OUT = c.a_dout;
  assign SIDE_A_DATA_OE_OUT = c.a_oe;
  assign SIDE_B_DATA_OUT = c.b_dout;
  assign SIDE_B_DATA_OE_OUT = c.b_oe;
  assign SIDE_A_ALMOST_EMPTY_N_OUT = c.flg[FLG_A_AE];
  assign SIDE_B_ALMOST_EMPTY_N_OUT = c.flg[FLG_B_AE];
  assign SIDE_A_ALMOST_FULL_N_OUT = c.flg[FLG_A_AF];
  assign SIDE_B_ALMOST_FULL_N_OUT = c.flg[FLG_B_AF];
  assign REG_RDATA_OUT = c.rdata;
  assign IRQ_OUT = c.irq;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  // port A driver turns on one cycle after a read-side select, port B driver is off one cycle after a write-side select
  a_bus_drive_a: assert property (SIDE_A_SELECT_IN && !SIDE_A_WRITE_EN_IN
    |=> SIDE_A_DATA_OE_OUT) else $error("port A bus not driven");
  b_bus_drive_a: assert property (SIDE_B_SELECT_IN && SIDE_B_WRITE_EN_IN
    |=> !SIDE_B_DATA_OE_OUT) else $error("port B bus driven on write");
  // flag pins lag their raw level by exactly two cycles
  a_empty_flag_a: assert property (##2 SIDE_A_ALMOST_EMPTY_N_OUT
    == $past(flg_raw[FLG_A_AE], 2)) else $error("port A almost-empty wrong");
  b_empty_flag_a: assert property (##2 SIDE_B_ALMOST_EMPTY_N_OUT
    == $past(flg_raw[FLG_B_AE], 2)) else $error("port B almost-empty wrong");
  a_full_flag_a: assert property (##2 SIDE_A_ALMOST_FULL_N_OUT
    == $past(flg_raw[FLG_A_AF], 2)) else $error("port A almost-full wrong");
  b_full_flag_a: assert property (##2 SIDE_B_ALMOST_FULL_N_OUT
    == $past(flg_raw[FLG_B_AF], 2)) else $error("port B almost-full wrong");
  // a flag raw change cannot reach the pin in the next cycle
  flag_two_stage_a: assert property ($changed(flg_raw) |=> c.flg != $past(flg_raw))
    else $error("flag not two-stage");
  // byte order caught during master reset
  big_order_a: assert property (!MASTER_RESET_N_IN && ORDER_TIMING_SELECT_IN
    |=> c.order) else $error("big-endian not latched");
  little_order_a: assert property (!MASTER_RESET_N_IN && !ORDER_TIMING_SELECT_IN
    |=> !c.order) else $error("little-endian not latched");
  // order holds and timing mode tracks the pin after master reset
  timing_mode_a: assert property (MASTER_RESET_N_IN && $past(MASTER_RESET_N_IN)
    |=> c.fall_through_select == !$past(ORDER_TIMING_SELECT_IN) && $stable(c.order))
    else $error("timing mode wrong");
  // default offsets loaded under master reset
  default_off_a: assert property (!MASTER_RESET_N_IN && !REG_WRITE_IN
    && {FLAG_DEFAULT_SEL1_IN, FLAG_DEFAULT_SEL0_IN} == DSEL_64
    |=> c.ab_full_off == CW'(DEF_OFF_64) && c.ba_empty_off == CW'(DEF_OFF_64))
    else $error("default offset not loaded");
endmodule

// ===== tb/bffs_peer.sv
`timescale 1ns/1ps
// controller model for one data port
module bffs_peer import bffs_pkg::*; (
  // clock
  input wire logic clk_in,
  // device side
  input wire logic [DATA_W-1:0] dout_in,
  input wire logic oe_in,
  output logic sel_out,
  output logic we_out,
  output logic re_out,
  output logic [DATA_W-1:0] din_out
);
  logic [DATA_W-1:0] drv_r;
  logic own_r;
  // released bus shows the inverse of the last word, never a stale copy
  assign din_out = oe_in ? dout_in : (own_r ? drv_r : ~drv_r);
  // idle levels
  initial begin
    sel_out = 1'b0;
    we_out = 1'b0;
    re_out = 1'b0;
    own_r = 1'b0;
    drv_r = '0;
  end
  // one write, select and strobe held up to the taking edge
  task automatic put(input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    sel_out <= 1'b1;
    we_out <= 1'b1;
    drv_r <= d;
    own_r <= 1'b1;
    @(posedge clk_in);
    sel_out <= 1'b0;
    we_out <= 1'b0;
    own_r <= 1'b0;
  endtask
  // one read, pop low only looks at the head
  task automatic get(input logic pop, output logic [DATA_W-1:0] d);
    @(posedge clk_in);
    sel_out <= 1'b1;
    re_out <= pop;
    @(posedge clk_in);
    re_out <= 1'b0;
    #1;
    d = dout_in;
    @(posedge clk_in);
    sel_out <= 1'b0;
  endtask
endmodule

// ===== tb/bffs_top_bench.sv
`timescale 1ns/1ps
// bench for flags, byte order and timing mode
module bffs_top_bench import bffs_pkg::*; ();
  localparam int QD = 128;
  localparam logic [DATA_W-1:0] W = 36'h9ABCD1234;
  localparam int DFLT [3] = '{DEF_OFF_8, DEF_OFF_16, DEF_OFF_64};
  logic clk, rst_n, mrs_n, ots, fs0, fs1, bmode, wr, rd, irq;
  logic a_sel, a_we, a_re, a_oe, a_ae, a_af, b_sel, b_we, b_re, b_oe, b_ae, b_af;
  logic [DATA_W-1:0] a_din, a_dout, b_din, b_dout, d;
  logic [ADDR_W-1:0] addr;
  logic [RDATA_W-1:0] wdata, rdata;
  int n_errors, checks_done;
  // device and one controller per port
  bffs_top #(.QDEPTH(QD)) u_bffs_top (.CLK_IN(clk), .RESET_N_IN(rst_n),
    .MASTER_RESET_N_IN(mrs_n), .ORDER_TIMING_SELECT_IN(ots), .FLAG_DEFAULT_SEL0_IN(fs0),
    .FLAG_DEFAULT_SEL1_IN(fs1), .SIDE_B_BYTE_MODE_IN(bmode), .SIDE_A_SELECT_IN(a_sel),
    .SIDE_A_WRITE_EN_IN(a_we), .SIDE_A_READ_EN_IN(a_re), .SIDE_A_DATA_IN(a_din),
    .SIDE_A_DATA_OUT(a_dout), .SIDE_A_DATA_OE_OUT(a_oe), .SIDE_A_ALMOST_EMPTY_N_OUT(a_ae),
    .SIDE_A_ALMOST_FULL_N_OUT(a_af), .SIDE_B_SELECT_IN(b_sel), .SIDE_B_WRITE_EN_IN(b_we),
    .SIDE_B_READ_EN_IN(b_re), .SIDE_B_DATA_IN(b_din), .SIDE_B_DATA_OUT(b_dout),
    .SIDE_B_DATA_OE_OUT(b_oe), .SIDE_B_ALMOST_EMPTY_N_OUT(b_ae),
    .SIDE_B_ALMOST_FULL_N_OUT(b_af), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WRITE_IN(wr), .REG_READ_IN(rd), .REG_RDATA_OUT(rdata), .IRQ_OUT(irq));
  bffs_peer u_bffs_peer_a (.clk_in(clk), .dout_in(a_dout), .oe_in(a_oe), .sel_out(a_sel),
    .we_out(a_we), .re_out(a_re), .din_out(a_din));
  bffs_peer u_bffs_peer_b (.clk_in(clk), .dout_in(b_dout), .oe_in(b_oe), .sel_out(b_sel),
    .we_out(b_we), .re_out(b_re), .din_out(b_din));
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard
  initial begin
    #100000;
    n_errors++;
    summarize();
  end
  task automatic summarize();
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // word compare
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // flag compare
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // settle point n edges on
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // register write and checked read
  task automatic rw(input logic [ADDR_W-1:0] a, input logic [RDATA_W-1:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rr(input logic [ADDR_W-1:0] a, input logic [RDATA_W-1:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(DATA_W'(rdata), DATA_W'(e));
  endtask
  // master reset, select then left at the mode level
  task automatic mrs(input logic ord, input logic mode, input logic [1:0] fs, input logic bm);
    @(posedge clk);
    ots <= ord;
    {fs1, fs0} <= fs;
    bmode <= bm;
    mrs_n <= 1'b0;
    repeat (2) @(posedge clk);
    mrs_n <= 1'b1;
    ots <= mode; // held static afterwards
    @(posedge clk);
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    mrs_n = 1'b1;
    ots = 1'b1;
    {fs1, fs0} = 2'h0;
    bmode = 1'b0;
    {wr, rd} = 2'h0;
    addr = '0;
    wdata = '0;
    n_errors = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk1(a_af, 1'b1);
    for (int i = 2; i >= 0; i--) begin
      mrs(1'b1, 1'b1, 2'(i), 1'b0);
      rr(OFF_AB_EMPTY, RDATA_W'(DFLT[i]));
      rr(OFF_BA_FULL, RDATA_W'(DFLT[i]));
    end
    rr(OFF_CONFIG, 32'h1);
    rw(OFF_CLEAR, 32'hF);
    rw(OFF_ENABLE, 32'h4);
    rw(OFF_AB_FULL, RDATA_W'(QD - 24));
    // a-to-b fill across both thresholds
    for (int i = 1; i <= 8; i++) u_bffs_peer_a.put(DATA_W'(i));
    tick(3);
    chk1(b_ae, 1'b0);
    u_bffs_peer_a.put(DATA_W'(9));
    tick(1);
    chk1(b_ae, 1'b0);
    tick(1);
    chk1(b_ae, 1'b1);
    for (int i = 10; i <= 23; i++) u_bffs_peer_a.put(DATA_W'(i));
    tick(3);
    chk1(a_af, 1'b1);
    u_bffs_peer_a.put(DATA_W'(24));
    tick(3);
    chk1(a_af, 1'b0);
    chk1(irq, 1'b1);
    rr(OFF_STATUS, 32'h4);
    rw(OFF_CLEAR, 32'h4);
    rr(OFF_STATUS, 32'h0);
    chk1(irq, 1'b0);
    rr(8'h20, 32'h0);
    for (int i = 1; i <= 24; i++) begin
      u_bffs_peer_b.get(1'b1, d);
      chk(d, DATA_W'(i));
    end
    // b-to-a with programmed offsets
    rw(OFF_BA_EMPTY, 32'h2);
    rw(OFF_BA_FULL, RDATA_W'(QD - 3));
    for (int i = 1; i <= 3; i++) begin
      u_bffs_peer_b.put(36'hA00000000 | DATA_W'(i));
      tick(3);
      chk1(a_ae, i > 2);
      chk1(b_af, i < 3);
    end
    for (int i = 1; i <= 3; i++) begin
      u_bffs_peer_a.get(1'b1, d);
      chk(d, 36'hA00000000 | DATA_W'(i));
    end
    // byte order for both select levels
    for (int o = 1; o >= 0; o--) begin
      mrs(1'(o), 1'b1, 2'h0, 1'b1);
      u_bffs_peer_a.put(W);
      tick(3);
      for (int k = 0; k < BYTES; k++) begin
        u_bffs_peer_b.get(1'b1, d);
        chk(d & 36'h1FF, (W >> (BYTE_W * (o ? BYTES - 1 - k : k))) & 36'h1FF);
      end
      // bytes written on B land in the same lanes of the A word
      for (int k = 0; k < BYTES; k++) begin
        u_bffs_peer_b.put((W >> (BYTE_W * (o ? BYTES - 1 - k : k))) & 36'h1FF);
      end
      tick(3);
      u_bffs_peer_a.get(1'b1, d);
      chk(d, W);
    end
    // fall-through shows the head with no read
    mrs(1'b1, 1'b0, 2'h0, 1'b0);
    rr(OFF_CONFIG, 32'h3);
    u_bffs_peer_a.put(W);
    tick(4);
    u_bffs_peer_b.get(1'b0, d);
    chk(d, W);
    summarize();
  end
endmodule
